// *** hw/bus_release_params.svh ***
// Constants of the memory bus release handshake: widths, timing figures and counts.
// Assumes the CPU clock period P equals the block clock period.
// Functional notes
// - Wait four periods before floating the bus.
// - Grant low within two periods of floating.
// - Redrive bus three to seven periods after release.
// - Grant high within two periods of redrive.
// - Pending transactions finish before the grant.
// - Priority set: eight SDRAM accesses before grant.
// - Ready-extended async access finishes before grant.
// - Idle bus releases with least delay.
// - Inhibit set: never release, never grant.
// - Released set covers strobes, enables, data, address.
`ifndef BUS_RELEASE_PARAMS_SVH
`define BUS_RELEASE_PARAMS_SVH

// Pin group widths of the external memory interface.
`define CE_W 4
`define BE_W 4
`define DATA_W 32
`define ADDR_W 20

// Clock periods in ns; the CPU period P is the unit of HIZ_MIN_P, RESUME_MIN_P and RESUME_MAX_P below.
`define CPU_PERIOD_NS 5
`define CLK_PERIOD_NS 5

// Least time from request low to high impedance, in P.
`define HIZ_MIN_P 4
// Least and longest time from request high to redrive, in P.
`define RESUME_MIN_P 3
`define RESUME_MAX_P 7

// Cycle counts derived from the figures; a least time rounds up.
`define HIZ_MIN_CYC ((`HIZ_MIN_P * `CPU_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESUME_MIN_CYC ((`RESUME_MIN_P * `CPU_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESUME_MAX_CYC ((`RESUME_MAX_P * `CPU_PERIOD_NS) / `CLK_PERIOD_NS)
// Synchroniser plus agreement register take three to four cycles, so one extra wait lands inside the window.
`define SYNC_LAT_CYC 3
`define RESUME_WAIT_CYC (`RESUME_MIN_CYC - `SYNC_LAT_CYC + 1)

// Consecutive SDRAM accesses owed when burst priority is set.
`define BURST_MIN_ACC 8
`define CNT_W 4

`endif

// *** hw/bus_release_pkg.sv ***
// Types shared by the memory bus release handshake.
// Assumes bus_release_params.svh supplies the widths.
`include "bus_release_params.svh"
`default_nettype none

package bus_release_pkg;

  // Handshake states from owning the bus to having lent it out and back.
  typedef enum logic [2:0] {
    OWNED,
    DRAINING,
    FLOATING,
    RELEASED,
    RESUMING,
    REDRIVE
  } release_state_e;

  // Every pin of the memory interface that is floated while the bus is lent out.
  typedef struct packed {
    logic [`CE_W-1:0] chip_enable_n;
    logic [`BE_W-1:0] byte_enable_n;
    logic [`DATA_W-1:0] memory_data_bus;
    logic [`ADDR_W-1:0] memory_word_address;
    logic async_read_strobe_n;
    logic async_output_enable_n;
    logic async_write_strobe_n;
    logic column_strobe_or_burst_addr_strobe;
    logic row_strobe_or_burst_output_enable;
    logic sync_write_enable_n;
    logic precharge_address_bit;
  } mem_bus_s;

endpackage

`default_nettype wire

// *** hw/request_sync.sv ***
// Three-stage synchroniser with agreement filter for a pin input.
// Assumes the input may change at any time relative to clk.
`include "bus_release_params.svh"
`default_nettype none

module request_sync (
  input wire logic clk, // Block clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable; state freezes while low.
  input wire logic pin_in, // Raw asynchronous pin level.
  output logic level // Filtered level, from a flip-flop.
);

  logic [2:0] stage; // Stage 0 is read only by stage 1.
  logic [2:0] next_stage; // Next shift value.
  logic next_level; // Next agreed level.

  // Shift the pin in and accept a change once stages 1 and 2 agree.
  always_comb begin
    next_stage = {stage[1:0], pin_in};
    next_level = level;
    if (stage[1] == stage[2]) begin
      next_level = stage[2];
    end
  end

  // Registers idle high, the inactive level of an active-low request.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage <= 3'h7;
      level <= 1'b1;
    end else if (ce) begin
      stage <= next_stage;
      level <= next_level;
    end
  end

endmodule // request_sync

`default_nettype wire

// *** hw/memory_bus_release_handshake.sv ***
// Lends the external memory interface to an outside master and takes it back.
// Assumes the memory controller reports busy, ready-extended and SDRAM access
// activity on clk, and honours stall_new_access by starting nothing new.
`include "bus_release_params.svh"
`default_nettype none

module memory_bus_release_handshake
  import bus_release_pkg::*;
(
  input wire logic clk, // Block clock, 200 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable; all state freezes while low.
  input wire logic bus_release_request_n, // Release request pin from the outside master.
  input wire logic grant_inhibit, // When high the bus is never lent out.
  input wire logic eight_access_burst_priority, // When high an SDRAM streak earns eight accesses.
  input wire logic mem_busy, // A memory transaction is in progress.
  input wire logic async_ready_input_stall, // An async access is extended by its ready input.
  input wire logic sdram_streak, // SDRAM accesses are running back to back.
  input wire logic sdram_access_done, // Pulse per completed SDRAM read or write.
  input wire mem_bus_s core_bus, // Pin values the controller wants to drive.
  input wire logic core_data_drive, // Controller drives the data bus (write).
  output mem_bus_s mem_pins, // Registered pin values.
  output logic bus_oe, // Enable for every control and address pin.
  output logic data_oe, // Enable for the data bus pins.
  output logic stall_new_access, // Asks the controller to start nothing new.
  output logic bus_release_grant_n // Release grant pin, active low.
);

  release_state_e state; // Handshake state.
  release_state_e next_state; // Next handshake state.
  logic [`CNT_W-1:0] wait_cnt; // Down counter for the minimum waits.
  logic [`CNT_W-1:0] next_wait_cnt; // Next wait count.
  logic [`CNT_W-1:0] burst_cnt; // SDRAM accesses done while draining.
  logic [`CNT_W-1:0] next_burst_cnt; // Next burst count.
  logic burst_owed; // An SDRAM streak still owes accesses.
  logic next_burst_owed; // Next burst owed flag.
  logic next_bus_oe; // Next pin enable.
  logic next_grant_n; // Next grant level.
  logic next_data_drive; // Next data drive request.
  logic data_drive; // Registered data drive request.
  logic req_n; // Synchronised request, active low.
  logic bus_quiet; // Nothing pending on the memory bus.

  // The request pin crosses into clk before any decision looks at it.
  request_sync u_request_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .pin_in(bus_release_request_n),
    .level(req_n)
  );

  // Both ordinary and ready-extended accesses must be finished.
  assign bus_quiet = !mem_busy && !async_ready_input_stall;

  // While draining, new work is held off unless an SDRAM streak is still owed accesses.
  assign stall_new_access = (state != OWNED) && !burst_owed;

  // Data pins float whenever the whole bus is floated.
  assign data_oe = bus_oe && data_drive;

  // Next state and counters of the handshake.
  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    next_burst_cnt = burst_cnt;
    next_burst_owed = burst_owed;
    next_bus_oe = bus_oe;
    next_grant_n = bus_release_grant_n;
    if (wait_cnt != '0) begin
      next_wait_cnt = wait_cnt - `CNT_W'(1);
    end
    unique case (state)
      OWNED: begin
        // Inhibit keeps the bus here however long the request stays low.
        if (!req_n && !grant_inhibit) begin
          next_state = DRAINING;
          next_wait_cnt = `CNT_W'(`HIZ_MIN_CYC - 1);
          next_burst_cnt = '0;
          next_burst_owed = eight_access_burst_priority && sdram_streak;
        end
      end
      DRAINING: begin
        if (sdram_access_done && burst_owed) begin
          next_burst_cnt = burst_cnt + `CNT_W'(1);
          if (burst_cnt == `CNT_W'(`BURST_MIN_ACC - 1)) begin
            next_burst_owed = 1'b0;
          end
        end
        if (req_n || grant_inhibit) begin
          // Request withdrawn or inhibited before release: keep the bus.
          next_state = OWNED;
          next_burst_owed = 1'b0;
        end else if (wait_cnt == '0 && bus_quiet && !burst_owed) begin
          next_state = FLOATING;
          next_bus_oe = 1'b0;
        end
      end
      FLOATING: begin
        // Grant follows the floated bus by one cycle.
        next_state = RELEASED;
        next_grant_n = 1'b0;
      end
      RELEASED: begin
        if (req_n) begin
          next_state = RESUMING;
          next_wait_cnt = `CNT_W'(`RESUME_WAIT_CYC - 1);
        end
      end
      RESUMING: begin
        if (wait_cnt == '0) begin
          next_state = REDRIVE;
          next_bus_oe = 1'b1;
        end
      end
      REDRIVE: begin
        // Grant withdrawn one cycle after the pins are driven again.
        next_state = OWNED;
        next_grant_n = 1'b1;
      end
    endcase
  end

  // Handshake registers; the grant comes out of reset high.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= OWNED;
      wait_cnt <= '0;
      burst_cnt <= '0;
      burst_owed <= 1'b0;
      bus_oe <= 1'b1;
      bus_release_grant_n <= 1'b1;
    end else if (ce) begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      burst_cnt <= next_burst_cnt;
      burst_owed <= next_burst_owed;
      bus_oe <= next_bus_oe;
      bus_release_grant_n <= next_grant_n;
    end
  end

  // Pin values are registered so the pads see clean flip-flop outputs.
  always_comb begin
    next_data_drive = core_data_drive;
  end

  // Pin value registers; reset shows every strobe inactive.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_pins <= '1;
      data_drive <= 1'b0;
    end else if (ce) begin
      mem_pins <= core_bus;
      data_drive <= next_data_drive;
    end
  end

  // Helper: cycles spent draining, for the minimum wait check.
  logic [`CNT_W-1:0] drain_age;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drain_age <= '0;
    end else if (ce) begin
      if (state != DRAINING) begin
        drain_age <= '0;
      end else if (drain_age != '1) begin
        drain_age <= drain_age + `CNT_W'(1);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst || !ce);

  // The synchronised request rises while the bus is lent out.
  sequence release_ends_s;
    state == RELEASED && req_n;
  endsequence

  // An idle bus sees a low request with nothing pending.
  sequence idle_request_s;
    state == OWNED && !req_n && !grant_inhibit && bus_quiet && !(eight_access_burst_priority && sdram_streak);
  endsequence

  // The quiet condition lasts through the minimum wait.
  sequence stays_quiet_s;
    (bus_quiet && !req_n && !grant_inhibit) [*4];
  endsequence

  hiz_min_wait_a: assert property ($fell(bus_oe) |-> $past(drain_age) >= `CNT_W'(`HIZ_MIN_CYC - 1))
    else $error("Bus floated before the minimum wait.");
  grant_after_hiz_a: assert property ($fell(bus_oe) |-> bus_release_grant_n ##[1:2] !bus_release_grant_n)
    else $error("Grant did not follow the floated bus.");
  redrive_window_a: assert property (release_ends_s |-> !bus_oe ##[1:3] bus_oe)
    else $error("Bus not driven again inside its window.");
  grant_after_redrive_a: assert property ($rose(bus_oe) |-> ##[0:2] bus_release_grant_n)
    else $error("Grant not withdrawn after redrive.");
  pending_done_a: assert property ($fell(bus_oe) |-> $past(bus_quiet))
    else $error("Bus floated with a transaction pending.");
  burst_owed_a: assert property ($fell(bus_oe) |-> !$past(burst_owed))
    else $error("Bus floated before the SDRAM streak was served.");
  burst_count_a: assert property ($fell(burst_owed) && state == DRAINING |-> burst_cnt == `CNT_W'(`BURST_MIN_ACC))
    else $error("SDRAM streak ended at the wrong count.");
  idle_fast_a: assert property (idle_request_s ##1 stays_quiet_s |-> ##[0:1] !bus_oe)
    else $error("Idle bus not released with least delay.");
  inhibit_hold_a: assert property (grant_inhibit && state == OWNED |=> state == OWNED)
    else $error("Bus left owned state while inhibited.");
  released_set_a: assert property (!bus_oe |-> !data_oe && stall_new_access)
    else $error("Data pins driven while bus released.");
  grant_needs_float_a: assert property (!bus_release_grant_n |-> !bus_oe || state == REDRIVE)
    else $error("Grant low while the bus is driven.");

endmodule // memory_bus_release_handshake

`default_nettype wire

// *** tb/bus_master_model.sv ***
// Behavioural outside master that borrows the external memory bus.
// Assumes the bench raises want to ask for the bus and lowers it to hand it back.
`default_nettype none

module bus_master_model (
  input wire logic clk, // Block clock.
  input wire logic want, // The bench wishes to own the bus.
  input wire logic bus_release_grant_n, // Grant from the device, active low.
  output logic bus_release_request_n // Request pin, active low.
);
  timeunit 1ns;
  timeprecision 1ps;

  int granted_cycles; // Edges seen with the grant low.

  // Start idle, with the request high, so the device sees no request out of reset.
  initial begin
    bus_release_request_n = 1'b1;
    granted_cycles = 0;
  end

  // The request changes just after a rising edge. Once granted it stays low one full period,
  // even when the bench lets go early; before a grant the master may withdraw at once.
  always @(posedge clk) begin
    if (bus_release_grant_n) begin
      granted_cycles <= 0;
    end else begin
      granted_cycles <= granted_cycles + 1;
    end
    bus_release_request_n <= !(want || (!bus_release_grant_n && granted_cycles < 1));
  end
endmodule // bus_master_model

`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the memory bus release handshake.
// Assumes a 200 MHz clock; the bench plays the memory controller, the model plays the master.
`default_nettype none

module tb;
  import bus_release_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0; // Block clock.
  logic nrst = 1'b0; // Reset, active low.
  logic ce = 1'b1; // Clock enable, dropped for one frozen spell in each idle handshake.
  logic want = 1'b0; // Bench asks the master model to borrow the bus.
  logic req_n; // Request pin from the model.
  logic grant_inhibit = 1'b0; // Keeps the bus at home when high.
  logic eight_access_burst_priority = 1'b0; // Grants an SDRAM streak eight accesses.
  logic mem_busy = 1'b0; // A transaction is in flight.
  logic async_ready_input_stall = 1'b0; // An async access is stretched.
  logic sdram_streak = 1'b0; // SDRAM accesses run back to back.
  logic sdram_access_done = 1'b0; // One pulse per SDRAM access.
  mem_bus_s core_bus = '0; // Pin values wanted by the controller.
  logic core_data_drive = 1'b1; // Controller drives the data bus.
  mem_bus_s mem_pins; // Registered pins.
  logic bus_oe; // Control and address enable.
  logic data_oe; // Data enable.
  logic stall_new_access; // No new access may start.
  logic grant_n; // Grant pin, active low.
  int failures = 0; // Mismatches seen.
  int checks = 0; // Comparisons made.
  int cycles = 0; // Clock cycles run, for the hang guard.

  memory_bus_release_handshake dut (.clk(clk), .nrst(nrst), .ce(ce), .bus_release_request_n(req_n),
    .grant_inhibit(grant_inhibit), .eight_access_burst_priority(eight_access_burst_priority),
    .mem_busy(mem_busy), .async_ready_input_stall(async_ready_input_stall), .sdram_streak(sdram_streak),
    .sdram_access_done(sdram_access_done), .core_bus(core_bus), .core_data_drive(core_data_drive),
    .mem_pins(mem_pins), .bus_oe(bus_oe), .data_oe(data_oe), .stall_new_access(stall_new_access),
    .bus_release_grant_n(grant_n));

  bus_master_model master (.clk(clk), .want(want), .bus_release_grant_n(grant_n), .bus_release_request_n(req_n));

  // Free-running clock; a hang costs a mismatch rather than a stuck run.
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      conclude();
    end
  end

  // One comparison of a design value, printed on a miss.
  task automatic chk(input string nm, input logic [$bits(mem_bus_s)-1:0] exp,
    input logic [$bits(mem_bus_s)-1:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // A measured delay must fall inside a window of cycles.
  task automatic rng(input string nm, input int lo, input int hi, input int got);
    checks = checks + 1;
    if (got < lo || got > hi) begin
      failures = failures + 1;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // Counts falling edges until a signal reaches a level, giving up after a bound.
  task automatic wait_lvl(ref logic sig, input logic val, input int lim, output int n);
    n = 0;
    while (sig !== val && n < lim) begin
      @(negedge clk);
      n = n + 1;
    end
  endtask

  // Hands the bus back and checks the redrive and grant return windows.
  task automatic give_back;
    int n;
    want = 1'b0;
    wait_lvl(req_n, 1'b1, 10, n);
    wait_lvl(bus_oe, 1'b1, 20, n);
    rng("redrive delay", 3, 7, n);
    wait_lvl(grant_n, 1'b1, 10, n);
    rng("grant return", 0, 2, n);
  endtask

  // Idle bus: fastest release, floating set, a frozen spell, then pins follow the controller again.
  // Each call passes its own pattern, so a stale value from an earlier call cannot pass the pin check.
  task automatic idle_handshake(input mem_bus_s pattern);
    int n;
    want = 1'b1;
    wait_lvl(req_n, 1'b0, 10, n);
    wait_lvl(bus_oe, 1'b0, 30, n);
    rng("float delay", 4, 9, n);
    chk("data enable floated", 1'b0, data_oe);
    wait_lvl(grant_n, 1'b0, 10, n);
    rng("grant delay", 0, 2, n);
    // With the clock enable low nothing may move, even though the master lets go meanwhile.
    ce = 1'b0;
    want = 1'b0;
    repeat (10) @(negedge clk);
    chk("bus frozen while disabled", 1'b0, bus_oe);
    chk("grant frozen while disabled", 1'b0, grant_n);
    ce = 1'b1;
    give_back();
    core_bus = pattern;
    @(negedge clk);
    chk("pins follow controller", pattern, mem_pins);
    chk("data enable driven", 1'b1, data_oe);
    core_data_drive = 1'b0;
    @(negedge clk);
    chk("data enable follows controller", 1'b0, data_oe);
    core_data_drive = 1'b1;
    @(negedge clk);
  endtask

  // Pending work, plain or ready-stretched, holds the grant off until it ends.
  task automatic pending_work;
    int n;
    mem_busy = 1'b1;
    want = 1'b1;
    repeat (25) @(negedge clk);
    chk("grant held for busy", 1'b1, grant_n);
    chk("stall while draining", 1'b1, stall_new_access);
    mem_busy = 1'b0;
    async_ready_input_stall = 1'b1;
    repeat (15) @(negedge clk);
    chk("bus held for stretched access", 1'b1, bus_oe);
    async_ready_input_stall = 1'b0;
    wait_lvl(grant_n, 1'b0, 15, n);
    chk("grant after work", 1'b0, grant_n);
    give_back();
  endtask

  // Burst priority owes eight SDRAM accesses before the bus may be lent.
  task automatic burst_owed;
    int n;
    eight_access_burst_priority = 1'b1;
    sdram_streak = 1'b1;
    want = 1'b1;
    repeat (8) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      chk("no stall while owed", 1'b0, stall_new_access);
      chk("no grant while owed", 1'b1, grant_n);
      sdram_access_done = 1'b1;
      @(negedge clk);
      sdram_access_done = 1'b0;
      @(negedge clk);
    end
    sdram_streak = 1'b0;
    wait_lvl(grant_n, 1'b0, 15, n);
    chk("grant after eight", 1'b0, grant_n);
    eight_access_burst_priority = 1'b0;
    give_back();
  endtask

  // Inhibit keeps the bus however long the request stands.
  task automatic inhibited;
    grant_inhibit = 1'b1;
    want = 1'b1;
    repeat (40) @(negedge clk);
    chk("bus kept under inhibit", 1'b1, bus_oe);
    chk("no grant under inhibit", 1'b1, grant_n);
    want = 1'b0;
    repeat (8) @(negedge clk);
    grant_inhibit = 1'b0;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (2) @(negedge clk);
    chk("grant in reset", 1'b1, grant_n);
    nrst = 1'b1;
    @(negedge clk);
    chk("bus driven after reset", 1'b1, bus_oe);
    idle_handshake(67'h5_5555_5555_5555_5555);
    pending_work();
    burst_owed();
    inhibited();
    idle_handshake(67'h2_AAAA_AAAA_AAAA_AAAA);
    conclude();
  end
endmodule // tb

`default_nettype wire
